// ### verilog/eau_regs.svh
// Constants for the effective-address unit: operation and group counts, limits.
// Assumes inclusion by bare name from the package.
// How it works
// - Indexed modes add index X or Y to the offset, unsigned.
// - Zero-offset indexed takes no byte; the index alone is the address.
// - Short indexed adds one fetched byte to the index, 000 to 1FE.
// - Long indexed adds a two-byte offset to the index over all 64 Kbyte.
// - Indirect modes fetch the pointer named by the next byte and use it.
// - Short indirect has byte pointer address and byte pointer, 00 to FF.
// - Long indirect forms fetch a 16-bit pointer from a byte address.
// - Indirect-indexed adds the index to the fetched pointer, unsigned.
// - Short indirect-indexed: byte pointers, sum from 000 to 1FE.
// - Relative mode adds an 8-bit two's-complement offset to the PC.
// - Direct relative takes the offset from the byte after the opcode.
// - Indirect relative fetches the offset at the address that follows.
// - Relative forms serve only conditional branches, JRA, JRT, JRF and relative call.
// - Load, compare, logic, arithmetic, bit compare: short and long.
// - Read-modify-write ops, bit ops, shifts other than SLA, call and jump: short only; SLA takes no mode.
// - The decoder knows 63 operations in 13 functional groups.
`ifndef EAU_REGS_SVH
`define EAU_REGS_SVH
`define EAU_OP_COUNT    63
`define EAU_GROUP_COUNT 13
`define EAU_PAGE0_MAX   16'h00FF
`define EAU_IDX_MAX     16'h01FE
`endif

// ### verilog/eau_pkg.sv
// Types shared by the effective-address unit.
// Assumes the constants header is on the include path.
`include "eau_regs.svh"
package eau_pkg;
  // Addressing submodes handled here
  typedef enum logic [3:0] {
    EAU_IDX0, EAU_IDX_S, EAU_IDX_L, EAU_IND_S, EAU_IND_L,
    EAU_IIX_S, EAU_IIX_L, EAU_REL_D, EAU_REL_I, EAU_DIR_S, EAU_DIR_L
  } eau_mode_e;
  // Operation families, 13 groups
  typedef enum logic [3:0] {
    EAU_G_LOAD, EAU_G_STACK, EAU_G_INCDEC, EAU_G_CMP, EAU_G_LOGIC,
    EAU_G_BIT, EAU_G_BTJ, EAU_G_ARITH, EAU_G_SHIFT, EAU_G_JUMP,
    EAU_G_CBR, EAU_G_INT, EAU_G_FLAG
  } eau_group_e;
  // Operations, 63 in all
  typedef enum logic [5:0] {
    EAU_LOAD_OP, EAU_ZERO_FILL_OP, EAU_PUSH, EAU_POP, EAU_RSP, EAU_INC,
    EAU_DEC, EAU_COMPARE_OP, EAU_SIGN_ZERO_TEST_OP, EAU_BIT_COMPARE_OP,
    EAU_AND, EAU_OR, EAU_XOR, EAU_CPL, EAU_NEG, EAU_BSET, EAU_BRES,
    EAU_BTJT, EAU_BTJF, EAU_ADC, EAU_ADD, EAU_SUB, EAU_SBC, EAU_MUL,
    EAU_SLL, EAU_SRL, EAU_SRA, EAU_RLC, EAU_RRC, EAU_SWAP, EAU_SLA,
    EAU_JRA, EAU_JRT, EAU_JRF, EAU_ABSOLUTE_JUMP_OP, EAU_CALL,
    EAU_RELATIVE_SUBROUTINE_INVOKE, EAU_NOP, EAU_RET,
    EAU_CRB_IH, EAU_CRB_IL, EAU_CRB_H, EAU_CRB_NH, EAU_CRB_M, EAU_CRB_NM,
    EAU_CRB_MI, EAU_CRB_PL, EAU_CRB_EQ, EAU_CRB_NE, EAU_CRB_C, EAU_CRB_NC,
    EAU_CRB_ULT, EAU_CRB_UGE, EAU_CRB_UGT, EAU_CRB_ULE,
    EAU_TRAP, EAU_WFI, EAU_HALT, EAU_IRET, EAU_SIM, EAU_RIM, EAU_SCF,
    EAU_RCF
  } eau_op_e;
  typedef enum logic [2:0] {
    EAU_ST_IDLE, EAU_ST_OPB0, EAU_ST_OPB1, EAU_ST_PTR0, EAU_ST_PTR1,
    EAU_ST_DONE
  } eau_state_e;
endpackage

// ### verilog/eau_mode_check.sv
// Decides which addressing submodes an operation may use.
// Assumes the mode and operation codes of the package; purely combinational.
module eau_mode_check (
  // Request
  input  wire eau_pkg::eau_op_e   op,
  input  wire eau_pkg::eau_mode_e mode,
  // Verdict
  output logic                    legal,
  output eau_pkg::eau_group_e     group
);
  logic full_set;
  logic short_set;
  logic rel_set;
  logic is_long;
  logic is_rel;

  always_comb begin
    group = eau_pkg::EAU_G_FLAG;
    unique case (op)
      eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_ZERO_FILL_OP:
        group = eau_pkg::EAU_G_LOAD;
      eau_pkg::EAU_PUSH, eau_pkg::EAU_POP, eau_pkg::EAU_RSP:
        group = eau_pkg::EAU_G_STACK;
      eau_pkg::EAU_INC, eau_pkg::EAU_DEC: group = eau_pkg::EAU_G_INCDEC;
      eau_pkg::EAU_COMPARE_OP, eau_pkg::EAU_SIGN_ZERO_TEST_OP,
      eau_pkg::EAU_BIT_COMPARE_OP: group = eau_pkg::EAU_G_CMP;
      eau_pkg::EAU_AND, eau_pkg::EAU_OR, eau_pkg::EAU_XOR, eau_pkg::EAU_CPL,
      eau_pkg::EAU_NEG: group = eau_pkg::EAU_G_LOGIC;
      eau_pkg::EAU_BSET, eau_pkg::EAU_BRES: group = eau_pkg::EAU_G_BIT;
      eau_pkg::EAU_BTJT, eau_pkg::EAU_BTJF: group = eau_pkg::EAU_G_BTJ;
      eau_pkg::EAU_ADC, eau_pkg::EAU_ADD, eau_pkg::EAU_SUB, eau_pkg::EAU_SBC,
      eau_pkg::EAU_MUL: group = eau_pkg::EAU_G_ARITH;
      eau_pkg::EAU_SLL, eau_pkg::EAU_SRL, eau_pkg::EAU_SRA, eau_pkg::EAU_RLC,
      eau_pkg::EAU_RRC, eau_pkg::EAU_SWAP, eau_pkg::EAU_SLA:
        group = eau_pkg::EAU_G_SHIFT;
      eau_pkg::EAU_JRA, eau_pkg::EAU_JRT, eau_pkg::EAU_JRF,
      eau_pkg::EAU_ABSOLUTE_JUMP_OP, eau_pkg::EAU_CALL,
      eau_pkg::EAU_RELATIVE_SUBROUTINE_INVOKE, eau_pkg::EAU_NOP,
      eau_pkg::EAU_RET: group = eau_pkg::EAU_G_JUMP;
      eau_pkg::EAU_TRAP, eau_pkg::EAU_WFI, eau_pkg::EAU_HALT,
      eau_pkg::EAU_IRET: group = eau_pkg::EAU_G_INT;
      eau_pkg::EAU_SIM, eau_pkg::EAU_RIM, eau_pkg::EAU_SCF, eau_pkg::EAU_RCF:
        group = eau_pkg::EAU_G_FLAG;
      default: group = eau_pkg::EAU_G_CBR;
    endcase
  end

  always_comb begin
    full_set = op inside {eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_COMPARE_OP,
      eau_pkg::EAU_AND, eau_pkg::EAU_OR, eau_pkg::EAU_XOR, eau_pkg::EAU_ADC,
      eau_pkg::EAU_ADD, eau_pkg::EAU_SUB, eau_pkg::EAU_SBC,
      eau_pkg::EAU_BIT_COMPARE_OP};
    short_set = op inside {eau_pkg::EAU_ZERO_FILL_OP, eau_pkg::EAU_INC,
      eau_pkg::EAU_DEC, eau_pkg::EAU_SIGN_ZERO_TEST_OP, eau_pkg::EAU_CPL,
      eau_pkg::EAU_NEG, eau_pkg::EAU_BSET, eau_pkg::EAU_BRES,
      eau_pkg::EAU_BTJT, eau_pkg::EAU_BTJF, eau_pkg::EAU_SLL,
      eau_pkg::EAU_SRL, eau_pkg::EAU_SRA, eau_pkg::EAU_RLC, eau_pkg::EAU_RRC,
      eau_pkg::EAU_SWAP, eau_pkg::EAU_CALL, eau_pkg::EAU_ABSOLUTE_JUMP_OP};
    rel_set = (group == eau_pkg::EAU_G_CBR) ||
      op inside {eau_pkg::EAU_JRA, eau_pkg::EAU_JRT, eau_pkg::EAU_JRF,
      eau_pkg::EAU_RELATIVE_SUBROUTINE_INVOKE};
    is_long = mode inside {eau_pkg::EAU_IDX_L, eau_pkg::EAU_IND_L,
      eau_pkg::EAU_IIX_L, eau_pkg::EAU_DIR_L};
    is_rel = mode inside {eau_pkg::EAU_REL_D, eau_pkg::EAU_REL_I};
    legal = is_rel ? rel_set : (full_set || (short_set && !is_long));
  end
endmodule

// ### verilog/eau_core.sv
// Effective-address unit: fetches operand bytes and pointers over the
// memory port and forms the operand address or branch target.
// Assumes a memory that answers one read per request with rd_valid.
module eau_core (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Request from the instruction sequencer
  input  wire logic               start,
  input  wire eau_pkg::eau_op_e   op,
  input  wire eau_pkg::eau_mode_e mode,
  input  wire logic               use_y,
  input  wire logic [7:0]         idx_x,
  input  wire logic [7:0]         idx_y,
  input  wire logic [15:0]        pc_next,
  // Memory read port
  output logic                    rd_req,
  output logic [15:0]             rd_addr,
  input  wire logic               rd_valid,
  input  wire logic [7:0]         rd_data,
  // Result
  output logic                    busy,
  output logic                    done,
  output logic                    illegal,
  output logic [15:0]             ea,
  output logic [3:0]              op_group,
  output logic [1:0]              extra_bytes
);
  typedef struct packed {
    eau_pkg::eau_state_e st;
    eau_pkg::eau_mode_e  mode;
    logic [7:0]          idx;
    logic [15:0]         pc;
    logic [15:0]         fetch_pc;
    logic [7:0]          b0;
    logic [7:0]          b1;
    logic [7:0]          p0;
    logic                done;
    logic                illegal;
    logic [15:0]         ea;
    logic [1:0]          extra;
  } eau_state_s;

  eau_state_s s_r;
  eau_state_s s_nxt;
  logic       legal;
  eau_pkg::eau_group_e grp;

  eau_mode_check u_check (
    .op    (op),
    .mode  (mode),
    .legal (legal),
    .group (grp)
  );

  // Unsigned base-plus-index sum; a byte base keeps the carry as bit 8, a word base wraps at 16 bits
  function automatic logic [15:0] idx_add(input logic [15:0] base,
                                          input logic [7:0] idx);
    idx_add = base + {8'h00, idx};
  endfunction

  // Operand bytes following the opcode for each submode
  function automatic logic [1:0] opnd_len(input eau_pkg::eau_mode_e m);
    unique case (m)
      eau_pkg::EAU_IDX0: opnd_len = 2'h0;
      eau_pkg::EAU_IDX_L, eau_pkg::EAU_DIR_L: opnd_len = 2'h2;
      default: opnd_len = 2'h1;
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    rd_req = 1'b0;
    rd_addr = s_r.fetch_pc;
    unique case (s_r.st)
      eau_pkg::EAU_ST_IDLE: begin
        if (start) begin
          s_nxt.mode = mode;
          s_nxt.idx = use_y ? idx_y : idx_x;
          s_nxt.pc = pc_next;
          s_nxt.fetch_pc = pc_next;
          s_nxt.extra = opnd_len(mode);
          s_nxt.b0 = 8'h00;
          s_nxt.b1 = 8'h00;
          s_nxt.p0 = 8'h00;
          s_nxt.illegal = !legal;
          if (!legal) begin
            s_nxt.st = eau_pkg::EAU_ST_DONE;
          end else if (mode == eau_pkg::EAU_IDX0) begin
            s_nxt.st = eau_pkg::EAU_ST_DONE;
          end else begin
            s_nxt.st = eau_pkg::EAU_ST_OPB0;
          end
        end
      end
      eau_pkg::EAU_ST_OPB0: begin
        rd_req = 1'b1;
        rd_addr = s_r.fetch_pc;
        if (rd_valid) begin
          s_nxt.b0 = rd_data;
          s_nxt.fetch_pc = s_r.fetch_pc + 16'h0001;
          unique case (s_r.mode)
            eau_pkg::EAU_IDX_L, eau_pkg::EAU_DIR_L:
              s_nxt.st = eau_pkg::EAU_ST_OPB1;
            eau_pkg::EAU_IND_S, eau_pkg::EAU_IND_L, eau_pkg::EAU_IIX_S,
            eau_pkg::EAU_IIX_L, eau_pkg::EAU_REL_I:
              s_nxt.st = eau_pkg::EAU_ST_PTR0;
            default: s_nxt.st = eau_pkg::EAU_ST_DONE;
          endcase
        end
      end
      eau_pkg::EAU_ST_OPB1: begin
        rd_req = 1'b1;
        rd_addr = s_r.fetch_pc;
        if (rd_valid) begin
          s_nxt.b1 = rd_data;
          s_nxt.st = eau_pkg::EAU_ST_DONE;
        end
      end
      eau_pkg::EAU_ST_PTR0: begin
        rd_req = 1'b1;
        rd_addr = {8'h00, s_r.b0};
        if (rd_valid) begin
          s_nxt.p0 = rd_data;
          if (s_r.mode inside {eau_pkg::EAU_IND_L, eau_pkg::EAU_IIX_L}) begin
            s_nxt.st = eau_pkg::EAU_ST_PTR1;
          end else begin
            s_nxt.st = eau_pkg::EAU_ST_DONE;
          end
        end
      end
      eau_pkg::EAU_ST_PTR1: begin
        rd_req = 1'b1;
        rd_addr = {8'h00, s_r.b0 + 8'h01};
        if (rd_valid) begin
          s_nxt.b1 = rd_data;
          s_nxt.st = eau_pkg::EAU_ST_DONE;
        end
      end
      eau_pkg::EAU_ST_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = eau_pkg::EAU_ST_IDLE;
        if (s_r.illegal) begin
          s_nxt.ea = 16'h0000;
        end else begin
          unique case (s_r.mode)
            eau_pkg::EAU_IDX0:
              s_nxt.ea = {8'h00, s_r.idx};
            eau_pkg::EAU_IDX_S:
              s_nxt.ea = idx_add({8'h00, s_r.b0}, s_r.idx);
            eau_pkg::EAU_IDX_L:
              s_nxt.ea = idx_add({s_r.b0, s_r.b1}, s_r.idx);
            eau_pkg::EAU_IND_S:
              s_nxt.ea = {8'h00, s_r.p0};
            eau_pkg::EAU_IND_L:
              s_nxt.ea = {s_r.p0, s_r.b1};
            eau_pkg::EAU_IIX_S:
              s_nxt.ea = idx_add({8'h00, s_r.p0}, s_r.idx);
            eau_pkg::EAU_IIX_L:
              s_nxt.ea = idx_add({s_r.p0, s_r.b1}, s_r.idx);
            eau_pkg::EAU_REL_D:
              s_nxt.ea = s_r.fetch_pc + {{8{s_r.b0[7]}}, s_r.b0};
            eau_pkg::EAU_REL_I:
              s_nxt.ea = s_r.fetch_pc + {{8{s_r.p0[7]}}, s_r.p0};
            eau_pkg::EAU_DIR_S:
              s_nxt.ea = {8'h00, s_r.b0};
            eau_pkg::EAU_DIR_L:
              s_nxt.ea = {s_r.b0, s_r.b1};
            default: s_nxt.ea = 16'h0000;
          endcase
        end
      end
      default: s_nxt.st = eau_pkg::EAU_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy        = (s_r.st != eau_pkg::EAU_ST_IDLE);
  assign done        = s_r.done;
  assign illegal     = s_r.illegal;
  assign ea          = s_r.ea;
  assign extra_bytes = s_r.extra;
  assign op_group    = grp;
endmodule

// ### verification/eau_mem_model.sv
// Memory bus model that answers the read port of eau_core.
// Assumes requests held until rd_valid; lat sets the wait states.
module eau_mem_model (
  // Bus
  input  wire logic        clock,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  input  wire logic [1:0]  lat,
  output logic             rd_valid,
  output logic [7:0]       rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  int         cnt;
  initial begin
    rd_valid = 1'b0;
    rd_data  = 8'h00;
    cnt      = 0;
  end
  // Data flips once released so a stale byte is never read as good
  always @(posedge clock) begin
    #1;
    if (rd_valid) begin
      rd_valid = 1'b0;
      rd_data  = ~rd_data;
      cnt      = 0;
    end else if (rd_req) begin
      if (cnt >= lat) begin
        rd_valid = 1'b1;
        rd_data  = mem[rd_addr];
      end else begin
        cnt++;
      end
    end
  end
endmodule

// ### verification/eau_core_monitor.sv
// Port checker for eau_core.
// Assumes binding from the testbench top; package compiled first.
module eau_core_monitor (
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic               start,
  input wire eau_pkg::eau_mode_e mode,
  input wire logic               rd_req,
  input wire logic [15:0]        rd_addr,
  input wire logic               rd_valid,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               illegal,
  input wire logic [15:0]        ea,
  input wire logic [1:0]         extra_bytes
);
  eau_pkg::eau_mode_e m_r;
  logic               ok;
  logic               go0;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m_r <= eau_pkg::EAU_IDX0;
    end else if (start && !busy) begin
      m_r <= mode;
    end
  end
  assign ok  = done && !illegal;
  assign go0 = start && !busy && mode == eau_pkg::EAU_IDX0;
  chk_idx0_timing: assert property (go0 |-> ##2 done)
    else $error("zero offset result late");
  chk_idx0_noread: assert property (go0 |=> !rd_req ##1 !rd_req)
    else $error("zero offset mode read memory");
  chk_page_zero: assert property (ok && m_r inside {eau_pkg::EAU_IDX0,
    eau_pkg::EAU_IND_S} |-> ea <= 16'h00FF) else $error("page zero overrun");
  chk_short_sum: assert property (ok &&
    m_r inside {eau_pkg::EAU_IDX_S, eau_pkg::EAU_IIX_S} |-> ea <= 16'h01FE)
    else $error("short sum overrun");
  chk_long_len: assert property (ok && m_r == eau_pkg::EAU_IDX_L
    |-> extra_bytes == 2'd2) else $error("long offset length wrong");
  chk_ptr_len: assert property (ok && m_r inside {eau_pkg::EAU_IND_S,
    eau_pkg::EAU_IND_L, eau_pkg::EAU_IIX_S, eau_pkg::EAU_IIX_L}
    |-> extra_bytes == 2'd1) else $error("pointer mode length wrong");
  chk_read_hold: assert property (rd_req && !rd_valid
    |=> rd_req && $stable(rd_addr)) else $error("read dropped early");
  chk_illegal_zero: assert property (done && illegal
    |-> ea == 16'h0000 && !busy) else $error("refused result not zero");
  cov_legal: cover property (ok);
  cov_refused: cover property (done && illegal);
  cov_wait: cover property (rd_req && !rd_valid ##1 rd_req);
endmodule

// ### verification/tb_cpu_effective_address_unit.sv
// Self-checking bench for eau_core with a memory model behind it.
// Assumes the package, design, model and checker are compiled first.
module tb_cpu_effective_address_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst_n = 1'b0, start = 1'b0, use_y = 1'b0;
  logic rd_req, rd_valid, busy, done, illegal;
  eau_pkg::eau_op_e   op   = eau_pkg::EAU_LOAD_OP;
  eau_pkg::eau_mode_e mode = eau_pkg::EAU_IDX0;
  logic [7:0]  idx_x = 8'h00, idx_y = 8'h00, rd_data;
  logic [15:0] pc_next = 16'h0000, rd_addr, ea;
  logic [3:0]  op_group;
  logic [1:0]  extra_bytes, lat = 2'd0;
  int          fails = 0, checks_done = 0;
  always #4 clock = ~clock;
  eau_core eau_core_inst (.clock(clock), .rst_n(rst_n), .start(start),
    .op(op), .mode(mode), .use_y(use_y), .idx_x(idx_x), .idx_y(idx_y),
    .pc_next(pc_next), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done),
    .illegal(illegal), .ea(ea), .op_group(op_group),
    .extra_bytes(extra_bytes));
  eau_mem_model eau_mem_model_inst (.clock(clock), .rd_req(rd_req),
    .rd_addr(rd_addr), .lat(lat), .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic chk(input logic [15:0] got, exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic run(input eau_pkg::eau_op_e o, input eau_pkg::eau_mode_e m,
                     input logic uy, input logic [7:0] x, y, input int pc);
    int n;
    op = o;
    mode = m;
    use_y = uy;
    idx_x = x;
    idx_y = y;
    pc_next = pc[15:0];
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    chk({15'h0000, done}, 16'h0001, "no result");
  endtask
  task automatic t_indexed();
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_IDX0, 0, 8'hFF, 8'h01, 'h0200);
    chk(ea, 16'h00FF, "index alone");
    chk({14'h0000, extra_bytes}, 16'h0000, "no offset byte");
    eau_mem_model_inst.mem[16'h0300] = 8'hFF;
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_IDX_S, 1, 8'h01, 8'hFF, 'h0300);
    chk(ea, 16'h01FE, "short index carry");
    chk({14'h0000, extra_bytes}, 16'h0001, "one offset byte");
    eau_mem_model_inst.mem[16'h0400] = 8'hFF;
    eau_mem_model_inst.mem[16'h0401] = 8'hF0;
    lat = 2'd2;
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_IDX_L, 0, 8'h20, 8'h00, 'h0400);
    chk(ea, 16'h0010, "long index wrap");
  endtask
  task automatic t_indirect();
    eau_mem_model_inst.mem[16'h0500] = 8'h10;
    eau_mem_model_inst.mem[16'h0010] = 8'hC3;
    run(eau_pkg::EAU_COMPARE_OP, eau_pkg::EAU_IND_S, 0, 8'h55, 8'h55, 'h0500);
    chk(ea, 16'h00C3, "byte pointer");
    eau_mem_model_inst.mem[16'h0600] = 8'hFF;
    eau_mem_model_inst.mem[16'h00FF] = 8'h12;
    eau_mem_model_inst.mem[16'h0000] = 8'h34;
    lat = 2'd0;
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_IND_L, 0, 8'h00, 8'h00, 'h0600);
    chk(ea, 16'h1234, "word pointer");
    eau_mem_model_inst.mem[16'h0700] = 8'h20;
    eau_mem_model_inst.mem[16'h0020] = 8'hFF;
    run(eau_pkg::EAU_BIT_COMPARE_OP, eau_pkg::EAU_IIX_S, 0, 8'hFF, 8'h0,
        'h0700);
    chk(ea, 16'h01FE, "byte pointer plus index");
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_IIX_L, 1, 8'h00, 8'h0F, 'h0600);
    chk(ea, 16'h1243, "word pointer plus index");
  endtask
  task automatic t_relative();
    eau_mem_model_inst.mem[16'h1000] = 8'h80;
    run(eau_pkg::EAU_CRB_EQ, eau_pkg::EAU_REL_D, 0, 8'h00, 8'h00, 'h1000);
    chk(ea, 16'h0F81, "backward branch");
    eau_mem_model_inst.mem[16'h2000] = 8'h30;
    eau_mem_model_inst.mem[16'h0030] = 8'h7F;
    run(eau_pkg::EAU_RELATIVE_SUBROUTINE_INVOKE, eau_pkg::EAU_REL_I, 0,
        8'h00, 8'h00, 'h2000);
    chk(ea, 16'h2080, "fetched displacement");
  endtask
  task automatic t_legality();
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_REL_D, 0, 8'h00, 8'h00, 'h1000);
    chk({15'h0000, illegal}, 16'h0001, "load took relative");
    run(eau_pkg::EAU_ZERO_FILL_OP, eau_pkg::EAU_IDX_L, 0, 8'h0, 8'h0, 'h400);
    chk({15'h0000, illegal}, 16'h0001, "clear took long");
    run(eau_pkg::EAU_SIGN_ZERO_TEST_OP, eau_pkg::EAU_IND_S, 0, 8'h0, 8'h0,
        'h0500);
    chk({15'h0000, illegal}, 16'h0000, "test refused short");
    chk(ea, 16'h00C3, "test pointer");
    run(eau_pkg::EAU_COMPARE_OP, eau_pkg::EAU_IDX_L, 0, 8'h20, 8'h0, 'h400);
    chk({15'h0000, illegal}, 16'h0000, "compare refused long");
    eau_mem_model_inst.mem[16'h0800] = 8'hA5;
    run(eau_pkg::EAU_ZERO_FILL_OP, eau_pkg::EAU_DIR_S, 0, 8'h0, 8'h0, 'h800);
    chk(ea, 16'h00A5, "clear short direct");
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_DIR_L, 0, 8'h0, 8'h0, 'h400);
    chk(ea, 16'hFFF0, "load long direct");
    chk({14'h0000, extra_bytes}, 16'h0002, "long direct length");
    op = eau_pkg::EAU_CRB_ULE;
    #1 chk({12'h000, op_group}, {12'h000, eau_pkg::EAU_G_CBR},
           "group");
  endtask
  // Reset in the middle of an operand byte fetch must leave the unit idle
  task automatic t_reset();
    lat = 2'd2;
    op = eau_pkg::EAU_LOAD_OP;
    mode = eau_pkg::EAU_IND_L;
    pc_next = 16'h0600;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    @(posedge clock);
    #1 chk(rd_addr, 16'h0600, "operand fetch address");
    chk({15'h0000, busy}, 16'h0001, "not busy in fetch");
    rst_n = 1'b0;
    #1 chk({10'h000, busy, done, illegal, rd_req, extra_bytes}, 16'h0000,
           "reset state");
    chk(ea, 16'h0000, "reset result");
    chk(rd_addr, 16'h0000, "reset address");
    @(posedge clock);
    #1 rst_n = 1'b1;
    @(posedge clock);
    #1 chk({12'h000, busy, done, illegal, rd_req}, 16'h0000,
           "state after release");
    run(eau_pkg::EAU_LOAD_OP, eau_pkg::EAU_IND_L, 0, 8'h00, 8'h00, 'h0600);
    chk(ea, 16'h1234, "word pointer after reset");
  endtask
  task automatic complete_run();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    t_indexed();
    t_indirect();
    t_relative();
    t_reset();
    t_legality();
    complete_run();
  end
endmodule
bind eau_core eau_core_monitor eau_core_monitor_inst (.clock(clock),
  .rst_n(rst_n), .start(start), .mode(mode), .rd_req(rd_req),
  .rd_addr(rd_addr), .rd_valid(rd_valid), .busy(busy), .done(done),
  .illegal(illegal), .ea(ea), .extra_bytes(extra_bytes));
